// File: logic/vf_curve_generator.sv
// Voltage/frequency curve generator: parameters, select routing and voltage command.
`timescale 1ns/100ps
`default_nettype none
`include "vf_curve_defs.svh"
module vf_curve_generator
    import vf_curve_pkg::*;
#(
    parameter int NPTS  = 5,
    parameter int NTERM = 12
) (
    // Clock and reset
    input  wire logic             mclk_i,
    input  wire logic             reset_i,
    // Parameter writes
    input  wire logic             wr_valid_i,
    input  wire param_wr_s        wr_i,
    output logic                  wr_refused_o,
    // Input terminals (pins)
    input  wire logic             second_set_term_i,
    input  wire logic [NTERM-1:0] gp_term_i,
    // Operating point
    input  wire logic [15:0]      freq_i,
    input  wire logic [15:0]      supply_volt_i,
    // Results
    output logic                  second_set_select_o,
    output logic [15:0]           volt_cmd_o
);
    typedef struct packed {
        logic [15:0]                 base_freq;
        logic [15:0]                 base_volt;
        logic [15:0]                 alt_freq;
        logic                        load_sq;
        logic [7:0]                  motor;
        curve_pt_s [NPTS-1:0]        pts;
        logic [NTERM-1:0][7:0]       assign_code;
        logic [2:0][NTERM:0]         sync;
        logic [NTERM:0]              filt;
        calc_phase_e                 phase;
        logic [31:0]                 num;
        logic [31:0]                 den;
        logic [15:0]                 offset;
        logic                        sub;
        logic                        refused;
        logic [15:0]                 volt_cmd;
    } core_s;

    core_s       st;
    core_s       next_st;
    logic        div_done;
    logic [31:0] quot;
    logic [15:0] eff_fb;
    logic [15:0] eff_vb;
    logic        five_pt;
    logic        sel;
    logic        bad;

    function automatic logic is_code(input logic [15:0] v);
        return (v == `VF_CODE_UNUSED) || (v == `VF_CODE_PCT95);
    endfunction

    function automatic logic [15:0] sat16(input logic [31:0] v);
        return (v > 32'h0000FFFF) ? 16'hFFFF : v[15:0];
    endfunction

    vf_divider #(.W(32)) divider (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .start_i (st.phase == PH_START),
        .num_i   (st.num),
        .den_i   (st.den),
        .busy_o  (),
        .done_o  (div_done),
        .quot_o  (quot)
    );

    always_comb begin
        logic [15:0] lo_f;
        logic [15:0] lo_v;
        logic [15:0] hi_f;
        logic [15:0] hi_v;
        logic [15:0] d;
        logic        any_code3;
        logic        code3_or;
        lo_f      = 16'h0000;
        lo_v      = 16'h0000;
        hi_f      = 16'h0000;
        hi_v      = 16'h0000;
        d         = wr_i.data;
        any_code3 = 1'b0;
        code3_or  = 1'b0;
        bad       = 1'b0;
        next_st   = st;
        next_st.refused = 1'b0;
        next_st.sync[0] = {second_set_term_i, gp_term_i};
        next_st.sync[1] = st.sync[0];
        next_st.sync[2] = st.sync[1];
        for (int b = 0; b <= NTERM; b++) begin
            if (st.sync[1][b] == st.sync[2][b]) begin
                next_st.filt[b] = st.sync[2][b];
            end
        end
        for (int k = 0; k < NTERM; k++) begin
            if (st.assign_code[k] == `VF_ASSIGN_SECOND) begin
                any_code3 = 1'b1;
                code3_or  = code3_or | st.filt[k];
            end
        end
        sel = any_code3 ? code3_or : st.filt[NTERM];
        // effective base frequency, motor 2 ignores alternate
        five_pt = (st.motor == `VF_MOTOR_5PT) && !is_code(st.base_volt);
        eff_fb  = (sel && st.alt_freq != `VF_CODE_UNUSED && st.motor != `VF_MOTOR_5PT) ? st.alt_freq : st.base_freq;
        if (st.base_volt == `VF_CODE_UNUSED) begin
            eff_vb = supply_volt_i;
        end else if (st.base_volt == `VF_CODE_PCT95) begin
            eff_vb = 16'(({16'h0000, supply_volt_i} * `VF_PCT_NUM) / `VF_PCT_DEN);
        end else begin
            eff_vb = (st.base_volt <= supply_volt_i) ? st.base_volt : supply_volt_i;
        end
        case (wr_i.sel)
            SEL_BASE_FREQ:  bad = d > `VF_FREQ_MAX;
            SEL_BASE_VOLT:  bad = is_code(d) ? (st.motor == `VF_MOTOR_5PT) : (d > `VF_VOLT_MAX);
            SEL_ALT_FREQ:   bad = d > `VF_FREQ_MAX && d != `VF_CODE_UNUSED;
            SEL_LOAD_CURVE: bad = d > 16'h0001;
            SEL_MOTOR_TYPE: begin
                bad = !(d[15:8] == 8'h00 && (d[7:0] == `VF_MOTOR_RST || d[7:0] == `VF_MOTOR_STD1
                        || d[7:0] == `VF_MOTOR_5PT || d[7:0] == `VF_MOTOR_STD20
                        || d[7:0] == `VF_MOTOR_STD120 || d[7:0] == `VF_MOTOR_STD210));
                bad = bad || (d[7:0] == `VF_MOTOR_5PT && is_code(st.base_volt));
            end
            SEL_PT_FREQ: begin
                bad = wr_i.idx >= 4'(NPTS) || (d > `VF_FREQ_MAX && d != `VF_CODE_UNUSED);
                for (int i = 0; i < NPTS; i++) begin
                    if (4'(i) != wr_i.idx && d != `VF_CODE_UNUSED && st.pts[i].freq == d) begin
                        bad = 1'b1;
                    end
                end
            end
            SEL_PT_VOLT:     bad = wr_i.idx >= 4'(NPTS) || d > `VF_VOLT_MAX;
            SEL_TERM_ASSIGN: bad = wr_i.idx >= 4'(NTERM) || d > 16'h00FF;
            default:         bad = 1'b1;
        endcase
        if (wr_valid_i) begin
            next_st.refused = bad;
            if (!bad) begin
                case (wr_i.sel)
                    SEL_BASE_FREQ:   next_st.base_freq = d;
                    SEL_BASE_VOLT:   next_st.base_volt = d;
                    SEL_ALT_FREQ:    next_st.alt_freq = d;
                    SEL_LOAD_CURVE:  next_st.load_sq = d[0];
                    SEL_MOTOR_TYPE:  next_st.motor = d[7:0];
                    SEL_PT_FREQ:     next_st.pts[wr_i.idx[2:0]].freq = d;
                    SEL_PT_VOLT:     next_st.pts[wr_i.idx[2:0]].volt = d;
                    SEL_TERM_ASSIGN: next_st.assign_code[wr_i.idx] = d[7:0];
                    default:         next_st.refused = 1'b1;
                endcase
            end
        end
        // bracket the operating frequency between points
        hi_f = eff_fb;
        hi_v = eff_vb;
        for (int i = 0; i < NPTS; i++) begin
            if (st.pts[i].freq != `VF_CODE_UNUSED && st.pts[i].freq < eff_fb) begin
                if (st.pts[i].freq <= freq_i && st.pts[i].freq >= lo_f) begin
                    lo_f = st.pts[i].freq;
                    lo_v = (st.pts[i].volt < eff_vb) ? st.pts[i].volt : eff_vb;
                end
                if (st.pts[i].freq > freq_i && st.pts[i].freq < hi_f) begin
                    hi_f = st.pts[i].freq;
                    hi_v = (st.pts[i].volt < eff_vb) ? st.pts[i].volt : eff_vb;
                end
            end
        end
        case (st.phase)
            PH_SETUP: begin
                next_st.phase  = PH_START;
                next_st.offset = 16'h0000;
                next_st.sub    = 1'b0;
                // hold base voltage at and above base frequency
                if (freq_i >= eff_fb || eff_fb == 16'h0000) begin
                    next_st.volt_cmd = eff_vb;
                    next_st.phase    = PH_SETUP;
                end else if (five_pt) begin
                    next_st.offset = lo_v;
                    next_st.sub    = hi_v < lo_v;
                    next_st.num    = {16'h0000, next_st.sub ? lo_v - hi_v : hi_v - lo_v}
                                     * {16'h0000, freq_i - lo_f};
                    next_st.den    = {16'h0000, hi_f - lo_f};
                end else if (st.load_sq) begin
                    next_st.num = {16'h0000, eff_vb} * {16'h0000, freq_i} / {16'h0000, eff_fb}
                                  * {16'h0000, freq_i};
                    next_st.den = {16'h0000, eff_fb};
                end else begin
                    next_st.num = {16'h0000, eff_vb} * {16'h0000, freq_i};
                    next_st.den = {16'h0000, eff_fb};
                end
            end
            PH_START: next_st.phase = PH_WAIT;
            PH_WAIT: begin
                if (div_done) begin
                    next_st.phase    = PH_SETUP;
                    next_st.volt_cmd = st.sub ? st.offset - sat16(quot)
                                              : sat16({16'h0000, st.offset} + {16'h0000, sat16(quot)});
                end
            end
            default: next_st.phase = PH_SETUP;
        endcase
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            st           <= '0;
            st.base_freq <= `VF_BASE_FREQ_RST;
            st.base_volt <= `VF_BASE_VOLT_RST;
            st.alt_freq  <= `VF_ALT_FREQ_RST;
            st.load_sq   <= `VF_LOAD_SQ_RST;
            st.motor     <= `VF_MOTOR_RST;
            st.pts         <= {NPTS{`VF_PT_FREQ_RST, `VF_PT_VOLT_RST}};
            st.assign_code <= {NTERM{`VF_ASSIGN_RST}};
        end else begin
            st <= next_st;
        end
    end

    assign wr_refused_o        = st.refused;
    assign second_set_select_o = sel;
    assign volt_cmd_o          = st.volt_cmd;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    base_freq_store_a: assert property (
        wr_valid_i && wr_i.sel == SEL_BASE_FREQ && wr_i.data <= `VF_FREQ_MAX
        |=> st.base_freq == $past(wr_i.data) && !wr_refused_o) else $error("base frequency not stored");
    pct95_volt_a: assert property (
        st.base_volt == `VF_CODE_PCT95
        |-> {16'h0000, eff_vb} * `VF_PCT_DEN <= {16'h0000, supply_volt_i} * `VF_PCT_NUM
        && ({16'h0000, eff_vb} + 32'h00000001) * `VF_PCT_DEN > {16'h0000, supply_volt_i} * `VF_PCT_NUM)
        else $error("95 percent wrong");
    volt_cap_a: assert property (
        $stable(eff_vb) [*2] ##1 st.phase == PH_SETUP |-> volt_cmd_o <= $past(eff_vb))
        else $error("voltage above cap");
    alt_select_a: assert property (
        sel && st.alt_freq != `VF_CODE_UNUSED && st.motor != `VF_MOTOR_5PT |-> eff_fb == st.alt_freq)
        else $error("alternate base not used");
    route_dflt_a: assert property (
        !(|{st.assign_code[0] == `VF_ASSIGN_SECOND}) && st.assign_code == {NTERM{`VF_ASSIGN_RST}}
        |-> sel == st.filt[NTERM]) else $error("default routing broken");
    motor_legal_a: assert property (
        wr_valid_i && wr_i.sel == SEL_MOTOR_TYPE && wr_i.data == 16'h0003 |=> wr_refused_o)
        else $error("illegal motor type taken");
    pt_range_a: assert property (
        wr_valid_i && wr_i.sel == SEL_PT_VOLT && wr_i.data > `VF_VOLT_MAX |=> wr_refused_o)
        else $error("point voltage range");
    code_refuse_a: assert property (
        wr_valid_i && wr_i.sel == SEL_BASE_VOLT && is_code(wr_i.data) && st.motor == `VF_MOTOR_5PT
        |=> wr_refused_o && $stable(st.base_volt)) else $error("coded base voltage taken");
    five_pt_gate_a: assert property (
        st.motor == `VF_MOTOR_5PT |-> !is_code(st.base_volt)) else $error("point curve without voltage");
    dup_freq_a: assert property (
        wr_valid_i && wr_i.sel == SEL_PT_FREQ && wr_i.idx == 4'h1 && wr_i.data != `VF_CODE_UNUSED
        && st.pts[0].freq == wr_i.data |=> wr_refused_o) else $error("duplicate frequency taken");
    calc_bound_a: assert property (
        st.phase == PH_START |-> ##[1:40] st.phase == PH_SETUP) else $error("calculation hung");
    above_base_a: assert property (
        st.phase == PH_SETUP && freq_i >= eff_fb |=> volt_cmd_o == $past(eff_vb))
        else $error("not held at base voltage");

    cover_refuse_c: cover property (wr_valid_i ##1 wr_refused_o);
    cover_five_pt_c: cover property (five_pt && st.phase == PH_WAIT && div_done);
    cover_alt_c: cover property (sel && eff_fb == st.alt_freq && st.alt_freq != st.base_freq);
endmodule
`default_nettype wire

// File: logic/vf_curve_defs.svh
// Timing-free constants for the voltage/frequency curve generator.
`ifndef VF_CURVE_DEFS_SVH
`define VF_CURVE_DEFS_SVH

`define VF_FREQ_MAX      16'h0190
`define VF_VOLT_MAX      16'h03E8
`define VF_CODE_UNUSED   16'h270F
`define VF_CODE_PCT95    16'h22B8
`define VF_BASE_FREQ_RST 16'h003C
`define VF_BASE_VOLT_RST 16'h270F
`define VF_ALT_FREQ_RST  16'h270F
`define VF_LOAD_SQ_RST   1'b1
`define VF_MOTOR_RST     8'h00
`define VF_PT_FREQ_RST   16'h270F
`define VF_PT_VOLT_RST   16'h0000
`define VF_MOTOR_5PT     8'h02
`define VF_MOTOR_STD1    8'h01
`define VF_MOTOR_STD20   8'h14
`define VF_MOTOR_STD120  8'h78
`define VF_MOTOR_STD210  8'hD2
`define VF_ASSIGN_SECOND 8'h03
`define VF_ASSIGN_RST    8'hFF
`define VF_PCT_NUM       32'h0000005F
`define VF_PCT_DEN       32'h00000064

`endif

// File: logic/vf_curve_pkg.sv
// Types shared by the voltage/frequency curve generator files.
package vf_curve_pkg;

    typedef enum logic [2:0] {
        SEL_BASE_FREQ,
        SEL_BASE_VOLT,
        SEL_ALT_FREQ,
        SEL_LOAD_CURVE,
        SEL_MOTOR_TYPE,
        SEL_PT_FREQ,
        SEL_PT_VOLT,
        SEL_TERM_ASSIGN
    } param_sel_e;

    typedef struct packed {
        param_sel_e  sel;
        logic [3:0]  idx;
        logic [15:0] data;
    } param_wr_s;

    typedef struct packed {
        logic [15:0] freq;
        logic [15:0] volt;
    } curve_pt_s;

    typedef enum logic [1:0] {
        PH_SETUP,
        PH_START,
        PH_WAIT
    } calc_phase_e;

endpackage

// File: logic/vf_divider.sv
// Iterative restoring unsigned divider, one quotient bit per clock.
`timescale 1ns/100ps
`default_nettype none
module vf_divider
    import vf_curve_pkg::*;
#(
    parameter int W = 32
) (
    // Clock and reset
    input  wire logic         mclk_i,
    input  wire logic         reset_i,
    // Request
    input  wire logic         start_i,
    input  wire logic [W-1:0] num_i,
    input  wire logic [W-1:0] den_i,
    // Answer
    output logic              busy_o,
    output logic              done_o,
    output logic [W-1:0]      quot_o
);
    typedef struct packed {
        logic [W-1:0] rem;
        logic [W-1:0] quot;
        logic [W-1:0] den;
        logic [7:0]   cnt;
        logic         busy;
        logic         done;
    } div_s;

    div_s st;
    div_s next_st;

    always_comb begin
        logic [W:0] trial;
        trial   = '0;
        next_st = st;
        next_st.done = 1'b0;
        if (start_i && !st.busy) begin
            next_st.rem  = '0;
            next_st.quot = num_i;
            next_st.den  = den_i;
            next_st.cnt  = 8'(W);
            next_st.busy = 1'b1;
        end else if (st.busy) begin
            trial = {st.rem, st.quot[W-1]};
            if (trial >= {1'b0, st.den}) begin
                trial = trial - {1'b0, st.den};
            end
            next_st.rem  = trial[W-1:0];
            next_st.quot = {st.quot[W-2:0], ({st.rem, st.quot[W-1]} >= {1'b0, st.den})};
            next_st.cnt  = st.cnt - 8'h01;
            if (st.cnt == 8'h01) begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign busy_o = st.busy;
    assign done_o = st.done;
    assign quot_o = st.quot;
endmodule
`default_nettype wire

// File: testbench/vf_power_stage_model.sv
// Behavioural model of the motor power stage fed by the voltage command.
`timescale 1ns/100ps
`default_nettype none
module vf_power_stage_model #(
    parameter int RAIL = 1000
) (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    // Command from the curve generator
    input  wire logic [15:0] volt_cmd_i,
    input  wire logic [15:0] freq_i,
    // Applied output
    output logic [15:0]      applied_volt_o,
    output logic [15:0]      applied_freq_o
);
    // The stage cannot pass more than its rail, so larger commands are clipped.
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            applied_volt_o <= 16'h0000;
            applied_freq_o <= 16'h0000;
        end else begin
            applied_volt_o <= (volt_cmd_i > 16'(RAIL)) ? 16'(RAIL) : volt_cmd_i;
            applied_freq_o <= freq_i;
        end
    end
endmodule
`default_nettype wire

// File: testbench/vf_curve_generator_tb.sv
// Self-checking testbench of the voltage/frequency curve generator.
`timescale 1ns/100ps
`default_nettype none
`include "vf_curve_defs.svh"
module vf_curve_generator_tb
    import vf_curve_pkg::*;
;
    typedef struct {logic [1:0] kind; logic [15:0] v; logic s;} note_s;
    logic        mclk_i, reset_i, wr_valid_i, second_set_term_i, wr_refused_o, second_set_select_o;
    param_wr_s   wr_i;
    logic [11:0] gp_term_i;
    logic [15:0] freq_i, supply_volt_i, volt_cmd_o, stage_volt, stage_freq;
    logic [15:0] bf, bv, alt, sup, pf[5], pv[5];
    logic [7:0]  motor, asg[12];
    logic        load, probe_q, wpend;
    logic [7:0]  codes[5] = '{8'h00, 8'h01, 8'h14, 8'h78, 8'hD2};
    note_s       notes[$];
    note_s       n;
    int          mismatches, compares, k;

    vf_curve_generator #(.NPTS(5), .NTERM(12)) vf_curve_generator_inst (
        .mclk_i(mclk_i), .reset_i(reset_i), .wr_valid_i(wr_valid_i), .wr_i(wr_i),
        .wr_refused_o(wr_refused_o), .second_set_term_i(second_set_term_i), .gp_term_i(gp_term_i),
        .freq_i(freq_i), .supply_volt_i(supply_volt_i), .second_set_select_o(second_set_select_o),
        .volt_cmd_o(volt_cmd_o));
    vf_power_stage_model #(.RAIL(1000)) vf_power_stage_model_inst (
        .mclk_i(mclk_i), .reset_i(reset_i), .volt_cmd_i(volt_cmd_o), .freq_i(freq_i),
        .applied_volt_o(stage_volt), .applied_freq_o(stage_freq));

    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    function automatic logic sel_now();
        logic any, o;
        any = 1'b0;
        o = 1'b0;
        for (int i = 0; i < 12; i++) if (asg[i] == `VF_ASSIGN_SECOND) begin
            any = 1'b1;
            o = o | gp_term_i[i];
        end
        return any ? o : second_set_term_i;
    endfunction

    function automatic logic [15:0] exp_volt(input logic [15:0] f);
        int vb, fb, fl, vl, fu, vu, pc;
        vb = (bv == `VF_CODE_UNUSED) ? int'(sup) : (bv == `VF_CODE_PCT95) ? int'(sup) * 95 / 100 :
             (bv < sup) ? int'(bv) : int'(sup);
        fb = (sel_now() && alt != `VF_CODE_UNUSED && motor != `VF_MOTOR_5PT) ? int'(alt) : int'(bf);
        if (int'(f) >= fb || fb == 0) return 16'(vb);
        if (motor == `VF_MOTOR_5PT) begin
            fl = 0;
            vl = 0;
            fu = fb;
            vu = vb;
            // Points at or above the base point are ignored; volts are clipped to the base voltage.
            for (int i = 0; i < 5; i++) if (pf[i] != `VF_CODE_UNUSED && int'(pf[i]) < fb) begin
                pc = (int'(pv[i]) < vb) ? int'(pv[i]) : vb;
                if (pf[i] <= f && int'(pf[i]) >= fl) begin
                    fl = int'(pf[i]);
                    vl = pc;
                end else if (pf[i] > f && int'(pf[i]) < fu) begin
                    fu = int'(pf[i]);
                    vu = pc;
                end
            end
            return 16'(vl + (vu - vl) * (int'(f) - fl) / (fu - fl));
        end
        if (!load) return 16'(vb * int'(f) / fb);
        return 16'((vb * int'(f) / fb) * int'(f) / fb);
    endfunction

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, s);
        end
    endtask

    task automatic wr(input param_sel_e s, input logic [3:0] i, input logic [15:0] d, input logic rf);
        @(posedge mclk_i);
        wr_valid_i <= 1'h1;
        wr_i <= '{sel: s, idx: i, data: d};
        notes.push_back('{kind: 2'h0, v: {15'h0000, rf}, s: 1'h0});
        if (!rf) begin
            case (s)
                SEL_BASE_FREQ:  bf = d;
                SEL_BASE_VOLT:  bv = d;
                SEL_ALT_FREQ:   alt = d;
                SEL_LOAD_CURVE: load = d[0];
                SEL_MOTOR_TYPE: motor = d[7:0];
                SEL_PT_FREQ:    pf[i] = d;
                SEL_PT_VOLT:    pv[i] = d;
                default:        asg[i] = d[7:0];
            endcase
        end
        @(posedge mclk_i);
        wr_valid_i <= 1'h0;
    endtask

    // The wait covers a full computation loop started just after the change, plus a second one.
    task automatic probe(input logic [15:0] f);
        @(posedge mclk_i);
        freq_i <= f;
        repeat (80) @(posedge mclk_i);
        notes.push_back('{kind: 2'h1, v: exp_volt(f), s: sel_now()});
        probe_q <= 1'h1;
        @(posedge mclk_i);
        probe_q <= 1'h0;
    endtask

    always @(posedge mclk_i) begin
        if (wpend || probe_q) begin
            if (notes.size() == 0) begin
                mismatches++;
                $display("CHECK FAILED note queue expected 1 seen 0");
            end else begin
                n = notes.pop_front();
                if (n.kind == 2'h0) chk("wr_refused_o", n.v, {15'h0000, wr_refused_o});
                else begin
                    chk("volt_cmd_o", n.v, volt_cmd_o);
                    chk("second_set_select_o", {15'h0000, n.s}, {15'h0000, second_set_select_o});
                    chk("stage_volt", n.v, stage_volt);
                    chk("stage_freq", freq_i, stage_freq);
                end
            end
        end
        wpend = wr_valid_i && !reset_i;
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (10000) @(posedge mclk_i);
        mismatches++;
        $display("CHECK FAILED watchdog expected done seen timeout");
        report_and_stop();
    end

    initial begin
        reset_i = 1'h1;
        wr_valid_i = 1'h0;
        wr_i = '0;
        second_set_term_i = 1'h0;
        gp_term_i = 12'h000;
        freq_i = 16'h0000;
        supply_volt_i = 16'h00C8;
        probe_q = 1'h0;
        wpend = 1'h0;
        bf = `VF_BASE_FREQ_RST;
        bv = `VF_BASE_VOLT_RST;
        alt = `VF_ALT_FREQ_RST;
        load = `VF_LOAD_SQ_RST;
        motor = `VF_MOTOR_RST;
        sup = 16'h00C8;
        for (int i = 0; i < 5; i++) pf[i] = `VF_PT_FREQ_RST;
        for (int i = 0; i < 5; i++) pv[i] = `VF_PT_VOLT_RST;
        for (int i = 0; i < 12; i++) asg[i] = `VF_ASSIGN_RST;
        void'($urandom(32'h08AF1434));
        repeat (20) @(posedge mclk_i);
        reset_i <= 1'h0;
        probe(16'h001E); // Square law at reset.
        probe(16'h003C); // Base point.
        probe(16'h005A); // Held above base.
        $display("test defaults done");
        wr(SEL_LOAD_CURVE, 4'h0, 16'h0002, 1'h1); // Bad code.
        wr(SEL_LOAD_CURVE, 4'h0, 16'h0000, 1'h0); // Linear curve.
        repeat (4) probe(16'($urandom_range(59, 0))); // Linear rise.
        $display("test load done");
        wr(SEL_BASE_VOLT, 4'h0, 16'h03E9, 1'h1); // Too high.
        wr(SEL_BASE_VOLT, 4'h0, `VF_CODE_PCT95, 1'h0); // Coded value.
        probe(16'h003C); // Scaled supply.
        wr(SEL_BASE_VOLT, 4'h0, 16'h0096, 1'h0); // Explicit value.
        supply_volt_i <= 16'h00FA;
        sup = 16'h00FA;
        probe(16'h001E); // Capped slope.
        probe(16'h0078); // Capped top.
        wr(SEL_BASE_VOLT, 4'h0, `VF_CODE_UNUSED, 1'h0); // Supply code.
        $display("test base voltage done");
        wr(SEL_BASE_FREQ, 4'h0, 16'h0191, 1'h1); // Too high.
        wr(SEL_BASE_FREQ, 4'h0, 16'h0190, 1'h0); // Upper bound.
        probe(16'h0064); // Slope from new base.
        wr(SEL_BASE_FREQ, 4'h0, 16'h0000, 1'h0); // Lower bound.
        probe(16'h0000); // Zero base gives base voltage.
        wr(SEL_BASE_FREQ, 4'h0, 16'h0032, 1'h0); // Working value.
        $display("test base frequency done");
        wr(SEL_ALT_FREQ, 4'h0, 16'h0191, 1'h1); // Too high.
        wr(SEL_ALT_FREQ, 4'h0, 16'h0064, 1'h0); // Alternate base.
        second_set_term_i <= 1'h1;
        probe(16'h0032); // Alternate in use.
        wr(SEL_ALT_FREQ, 4'h0, `VF_CODE_UNUSED, 1'h0); // Disabled.
        probe(16'h0032); // Normal base again.
        wr(SEL_ALT_FREQ, 4'h0, 16'h0064, 1'h0); // Alternate base.
        $display("test second set done");
        k = $urandom_range(11, 0);
        wr(SEL_TERM_ASSIGN, 4'(k), 16'h0003, 1'h0); // Move the select.
        wr(SEL_TERM_ASSIGN, 4'hC, 16'h0003, 1'h1); // No such terminal.
        wr(SEL_TERM_ASSIGN, 4'(k), 16'h0100, 1'h1); // Code too wide.
        repeat (3) begin
            @(posedge mclk_i);
            gp_term_i <= 12'($urandom());
            probe(16'h0019); // Select from the assigned pin.
        end
        wr(SEL_TERM_ASSIGN, 4'(k), 16'h00FF, 1'h0); // Back to dedicated pin.
        probe(16'h0019); // Dedicated pin again.
        $display("test terminals done");
        foreach (codes[j]) wr(SEL_MOTOR_TYPE, 4'h0, {8'h00, codes[j]}, 1'h0); // Legal codes.
        wr(SEL_MOTOR_TYPE, 4'h0, 16'h0003, 1'h1); // Illegal code.
        wr(SEL_MOTOR_TYPE, 4'h0, 16'h0002, 1'h1); // Coded base voltage.
        wr(SEL_BASE_VOLT, 4'h0, 16'h00C8, 1'h0); // Explicit value.
        wr(SEL_MOTOR_TYPE, 4'h0, 16'h0002, 1'h0); // Point curve.
        wr(SEL_BASE_VOLT, 4'h0, `VF_CODE_PCT95, 1'h1); // Refused code.
        wr(SEL_BASE_VOLT, 4'h0, `VF_CODE_UNUSED, 1'h1); // Refused code.
        probe(16'h0032); // Alternate ignored.
        probe(16'h0019); // No points set.
        $display("test motor type done");
        wr(SEL_PT_FREQ, 4'h0, 16'h000A, 1'h0); // First point.
        wr(SEL_PT_VOLT, 4'h0, 16'h0028, 1'h0); // First point.
        wr(SEL_PT_FREQ, 4'h1, 16'h0014, 1'h0); // Second point.
        wr(SEL_PT_VOLT, 4'h1, 16'h003C, 1'h0); // Second point.
        wr(SEL_PT_FREQ, 4'h2, 16'h000A, 1'h1); // Same frequency.
        wr(SEL_PT_FREQ, 4'h1, 16'h000A, 1'h1); // Second point onto first.
        wr(SEL_PT_FREQ, 4'h5, 16'h001E, 1'h1); // No such point.
        wr(SEL_PT_FREQ, 4'h2, 16'h0191, 1'h1); // Too high.
        wr(SEL_PT_VOLT, 4'h2, 16'h03E9, 1'h1); // Too high.
        wr(SEL_PT_FREQ, 4'h2, `VF_CODE_UNUSED, 1'h0); // Unused mark.
        probe(16'h0005); // Origin to first point.
        probe(16'h000F); // Between points.
        probe(16'h0023); // Last point to base.
        $display("test five point done");
        repeat (2) @(posedge mclk_i);
        report_and_stop();
    end
endmodule
`default_nettype wire
